// [src/serial_port_defines.svh]
// Constants of the serial port status block: offsets, fields, resets.
// Assumes inclusion by bare name; definitions only.
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH

// Register byte offsets on the APB bus
`define OFS_STATUS 8'h00
`define OFS_DATA 8'h04
`define OFS_CONTROL 8'h08
`define OFS_EVENT 8'h0C
`define OFS_MASK 8'h10

// Status and event bit positions
`define BIT_TX_EMPTY 7
`define BIT_TX_DONE 6
`define BIT_RX_FULL 5
`define BIT_IDLE 4
`define BIT_OVERRUN 3
`define BIT_NOISE 2
`define BIT_FRAMING 1
`define BIT_PARITY 0

// Control register bit positions
`define BIT_PARITY_TYPE 0
`define BIT_PARITY_ENABLE 1
`define BIT_IDLE_SELECT 2
`define BIT_NINE_BITS 3
`define BIT_TX_ENABLE 4
`define BIT_SEND_BREAK 5

// Reset values
`define RST_STATUS 8'hC0
`define RST_CONTROL 8'h00
`define RST_MASK 8'h00

// Timing counts: oversample ticks, sample votes and frame lengths in bits
`define OVERSAMPLE 5'd16
`define SUB_LAST 4'hF
`define START_SMP_FIRST 4'h3
`define START_SMP_LAST 4'h9
`define BIT_SMP_FIRST 4'h7
`define BIT_SMP_LAST 4'h9
`define START_MAJ 3'd4
`define BIT_MAJ 3'd2
`define FRAME_SHORT 4'd10
`define FRAME_LONG 4'd11

`endif

// [src/serial_port_pkg.sv]
// Types shared by the serial port status block.
// Assumes nothing beyond a SystemVerilog compiler.
package serial_port_pkg;
  // Receiver sequencer, one-hot
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } rx_state_t;
  // Transmit shifter, one-hot
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;
endpackage

// [src/serial_rx_sampler.sv]
// Receive shifter with oversampled majority voting and idle counting.
// Assumes a synchronised line and a tick at sixteen per bit time.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defines.svh"
module serial_rx_sampler
  import serial_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic line_i,
  input wire logic nine_i,
  input wire logic idle_sel_i,
  output logic done_o,
  output logic [8:0] data_o,
  output logic noise_o,
  output logic frame_o,
  output logic idle_o
);
  rx_state_t state_q; // Sequencer
  logic [3:0] sub_q; // Tick within a bit
  logic [3:0] bitn_q; // Data bits taken
  logic [2:0] ones_q; // High samples in the current bit
  logic [8:0] sh_q; // Data shifter
  logic noise_q; // Any disagreeing sample so far
  logic [7:0] idle_cnt_q; // High ticks seen while counting
  logic smp; // This tick is a sample point
  logic bit_val; // Majority of the finished bit
  logic bit_noisy; // Samples of the finished bit disagree
  logic [7:0] idle_lim; // Ticks in one character time

  // Seven samples in the start bit, three in each other bit
  always_comb
  begin
    if (state_q == RX_START)
      smp = sub_q >= `START_SMP_FIRST && sub_q <= `START_SMP_LAST;
    else
      smp = sub_q >= `BIT_SMP_FIRST && sub_q <= `BIT_SMP_LAST;
    bit_val = ones_q >= `BIT_MAJ;
    bit_noisy = ones_q != 3'd0 && ones_q != 3'd3;
    idle_lim = (nine_i ? {4'd0, `FRAME_LONG} : {4'd0, `FRAME_SHORT}) << 4;
  end

  // Frame sequencer; a start that votes high is a glitch and is dropped
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= RX_IDLE;
      sub_q <= 4'h0;
      bitn_q <= 4'h0;
      ones_q <= 3'd0;
      sh_q <= 9'h000;
      noise_q <= 1'b0;
      done_o <= 1'b0;
      data_o <= 9'h000;
      noise_o <= 1'b0;
      frame_o <= 1'b0;
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      if (tick_i)
      begin
        sub_q <= sub_q + 4'h1;
        if (smp && state_q != RX_IDLE)
          ones_q <= ones_q + {2'b00, line_i};
        case (state_q)
          RX_IDLE:
          begin
            sub_q <= 4'h0;
            ones_q <= 3'd0;
            noise_q <= 1'b0;
            if (!line_i)
              state_q <= RX_START;
          end
          RX_START:
            if (sub_q == `SUB_LAST)
            begin
              ones_q <= 3'd0;
              bitn_q <= 4'h0;
              if (ones_q >= `START_MAJ)
                state_q <= RX_IDLE;
              else
              begin
                noise_q <= ones_q != 3'd0;
                state_q <= RX_DATA;
              end
            end
          RX_DATA:
            if (sub_q == `SUB_LAST)
            begin
              ones_q <= 3'd0;
              sh_q <= {bit_val, sh_q[8:1]};
              noise_q <= noise_q | bit_noisy;
              bitn_q <= bitn_q + 4'h1;
              if (bitn_q == (nine_i ? 4'd8 : 4'd7))
                state_q <= RX_STOP;
            end
          RX_STOP:
            if (sub_q == `SUB_LAST)
            begin
              done_o <= 1'b1;
              data_o <= nine_i ? sh_q : {1'b0, sh_q[8:1]};
              noise_o <= noise_q | bit_noisy;
              frame_o <= !bit_val;
              state_q <= RX_IDLE;
            end
          default:
            state_q <= RX_IDLE;
        endcase
      end
    end
  end

  // Idle timer: with select low it runs from the end of the start bit
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      idle_cnt_q <= 8'h00;
      idle_o <= 1'b0;
    end
    else if (ce_i)
    begin
      idle_o <= 1'b0;
      if (tick_i)
      begin
        if (!line_i || state_q == RX_START ||
            (idle_sel_i && state_q != RX_IDLE))
          idle_cnt_q <= 8'h00;
        else if (idle_cnt_q != idle_lim)
        begin
          idle_cnt_q <= idle_cnt_q + 8'h01;
          idle_o <= idle_cnt_q == idle_lim - 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [src/serial_tx_shifter.sv]
// Transmit shifter for data, preamble (all ones) and break (all zeros).
// Assumes a tick at sixteen per bit time; loads only while not busy.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defines.svh"
module serial_tx_shifter
  import serial_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic nine_i,
  input wire logic load_i,
  input wire logic [10:0] frame_i,
  output logic busy_o,
  output logic txd_o
);
  tx_state_t state_q; // Shifter state
  logic [10:0] sh_q; // Frame, sent LSB first
  logic [3:0] left_q; // Bits still to send
  logic [3:0] sub_q; // Tick within a bit

  // Shift one bit per sixteen ticks; line rests high
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= TX_IDLE;
      sh_q <= 11'h7FF;
      left_q <= 4'h0;
      sub_q <= 4'h0;
      busy_o <= 1'b0;
      txd_o <= 1'b1;
    end
    else if (ce_i)
    begin
      case (state_q)
        TX_IDLE:
          if (load_i)
          begin
            sh_q <= frame_i;
            left_q <= nine_i ? `FRAME_LONG : `FRAME_SHORT;
            sub_q <= 4'h0;
            busy_o <= 1'b1;
            state_q <= TX_SHIFT;
          end
        TX_SHIFT:
          if (tick_i)
          begin
            if (sub_q == 4'h0)
            begin
              txd_o <= sh_q[0];
              sh_q <= {1'b1, sh_q[10:1]};
            end
            sub_q <= sub_q + 4'h1;
            if (sub_q == `SUB_LAST)
            begin
              left_q <= left_q - 4'h1;
              if (left_q == 4'h1)
              begin
                busy_o <= 1'b0;
                txd_o <= 1'b1;
                state_q <= TX_IDLE;
              end
            end
          end
        default:
          state_q <= TX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [src/serial_status_top.sv]
// Status flags of a serial port with APB register access.
// Assumes APB master on SYS_CLK_I and an asynchronous receive pin.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defines.svh"
module serial_status_top
  import serial_port_pkg::*;
#(
  parameter int BAUD_DIV = 8 // Clock cycles per oversample tick
)
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic CLK_EN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic RXD_I,
  output logic TXD_O,
  output logic IRQ_O
);
  import serial_port_pkg::*;

  logic [7:0] status_q; // Flag register
  logic [7:0] seen_q; // Flags seen set by the last status read
  logic [7:0] ctrl_q; // Control register
  logic [7:0] event_q; // Sticky interrupt status
  logic [7:0] mask_q; // Interrupt mask
  logic [8:0] rx_data_q; // Receive data register
  logic [8:0] tx_buf_q; // Transmit buffer
  logic pre_pend_q; // Queued preamble
  logic brk_pend_q; // Queued break
  logic idle_arm_q; // Idle detection armed
  logic done_cond_q; // Last cycle's completion condition
  logic [15:0] div_q; // Oversample divider
  logic tick_q; // Oversample tick
  logic rx_s1_q, rx_s2_q, rx_s3_q; // Receive pin synchroniser
  logic rx_line_q; // Filtered receive level
  logic access; // APB transfer completes this edge
  logic wr_data, rd_data, rd_status; // Side-effecting accesses
  logic wr_ctrl, wr_event;
  logic te_rise, brk_write; // Transmitter actions
  logic brk_req; // Break wanted by pending or held bit
  logic tx_busy, tx_load, tx_data_go;
  logic [10:0] tx_frame; // Frame handed to the shifter
  logic tx_idle_cond; // Transmitter fully quiet
  logic rx_done, rx_noise, rx_frame, rx_idle;
  logic [8:0] rx_word;
  logic rx_accept, rx_perr;
  logic [7:0] set_v, clr_v; // Flag set and clear vectors
  logic mapped; // Address hits a register
  logic [31:0] rd_mux; // Read data before the register

  // Parity over the used data bits: nine or eight
  function automatic logic par_of(input logic [8:0] d, input logic nine);
    par_of = nine ? ^d : ^d[7:0];
  endfunction

  // Bus decode for completed transfers
  always_comb
  begin
    access = PSEL_I && PENABLE_I && PREADY_O;
    wr_data = access && PWRITE_I && PADDR_I == `OFS_DATA;
    rd_data = access && !PWRITE_I && PADDR_I == `OFS_DATA;
    rd_status = access && !PWRITE_I && PADDR_I == `OFS_STATUS;
    wr_ctrl = access && PWRITE_I && PADDR_I == `OFS_CONTROL;
    wr_event = access && PWRITE_I && PADDR_I == `OFS_EVENT;
    te_rise = wr_ctrl && PWDATA_I[`BIT_TX_ENABLE] &&
              !ctrl_q[`BIT_TX_ENABLE];
    brk_write = wr_ctrl && PWDATA_I[`BIT_SEND_BREAK];
    mapped = PADDR_I == `OFS_STATUS || PADDR_I == `OFS_DATA ||
             PADDR_I == `OFS_CONTROL || PADDR_I == `OFS_EVENT ||
             PADDR_I == `OFS_MASK;
  end

  // Read multiplexer; bits above each register read as zero
  always_comb
  begin
    case (PADDR_I)
      `OFS_STATUS: rd_mux = {24'h000000, status_q};
      `OFS_DATA: rd_mux = {23'h000000, rx_data_q};
      `OFS_CONTROL: rd_mux = {24'h000000, ctrl_q};
      `OFS_EVENT: rd_mux = {24'h000000, event_q};
      `OFS_MASK: rd_mux = {24'h000000, mask_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // APB answer: one wait state, then ready with registered data
  always_ff @(posedge SYS_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      PREADY_O <= PSEL_I && PENABLE_I && !PREADY_O;
      if (PSEL_I && PENABLE_I && !PREADY_O)
      begin
        PRDATA_O <= PWRITE_I ? 32'h00000000 : rd_mux;
        PSLVERR_O <= !mapped;
      end
      else
        PSLVERR_O <= 1'b0;
    end
  end

  // Control and mask registers; status offset takes no writes
  always_ff @(posedge SYS_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      ctrl_q <= `RST_CONTROL;
      mask_q <= `RST_MASK;
    end
    else if (CLK_EN_I)
    begin
      if (wr_ctrl)
        ctrl_q <= PWDATA_I[7:0];
      if (access && PWRITE_I && PADDR_I == `OFS_MASK)
        mask_q <= PWDATA_I[7:0];
    end
  end

  // Oversample tick, sixteen per bit time
  always_ff @(posedge SYS_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      tick_q <= div_q == 16'(BAUD_DIV - 1);
      div_q <= div_q == 16'(BAUD_DIV - 1) ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // Pin synchroniser; level follows once stages two and three agree
  always_ff @(posedge SYS_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
      rx_line_q <= 1'b1;
    end
    else if (CLK_EN_I)
    begin
      rx_s1_q <= RXD_I;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q)
        rx_line_q <= rx_s3_q;
    end
  end

  // Transmit choice: break first, then preamble, then buffered data
  always_comb
  begin
    brk_req = brk_pend_q || ctrl_q[`BIT_SEND_BREAK];
    tx_load = ctrl_q[`BIT_TX_ENABLE] && !tx_busy &&
              (brk_req || pre_pend_q || !status_q[`BIT_TX_EMPTY]);
    tx_data_go = tx_load && !brk_req && !pre_pend_q;
    if (brk_req)
      tx_frame = 11'h000;
    else if (pre_pend_q)
      tx_frame = 11'h7FF;
    else if (ctrl_q[`BIT_NINE_BITS])
      tx_frame = {1'b1, ctrl_q[`BIT_PARITY_ENABLE] ?
                  (par_of(tx_buf_q, 1'b0) ^ ctrl_q[`BIT_PARITY_TYPE]) :
                  tx_buf_q[8], tx_buf_q[7:0], 1'b0};
    else
      tx_frame = {2'b11, ctrl_q[`BIT_PARITY_ENABLE] ?
                  (^tx_buf_q[6:0] ^ ctrl_q[`BIT_PARITY_TYPE]) :
                  tx_buf_q[7], tx_buf_q[6:0], 1'b0};
    tx_idle_cond = status_q[`BIT_TX_EMPTY] && !tx_busy && !tx_load &&
                   !brk_req && !pre_pend_q;
  end

  // Queued preamble on enable rising, queued break on break write
  always_ff @(posedge SYS_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      pre_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
      tx_buf_q <= 9'h000;
      done_cond_q <= 1'b1;
    end
    else if (CLK_EN_I)
    begin
      done_cond_q <= tx_idle_cond;
      if (te_rise)
        pre_pend_q <= 1'b1;
      else if (tx_load && !brk_req)
        pre_pend_q <= 1'b0;
      if (brk_write)
        brk_pend_q <= 1'b1;
      else if (tx_load && brk_req)
        brk_pend_q <= 1'b0;
      if (wr_data)
        tx_buf_q <= PWDATA_I[8:0];
    end
  end

  // Receive acceptance; a data read in the same cycle frees the register if the last status read saw it full
  always_comb
  begin
    rx_accept = rx_done && !(status_q[`BIT_RX_FULL] &&
                !(rd_data && seen_q[`BIT_RX_FULL]));
    rx_perr = ctrl_q[`BIT_PARITY_ENABLE] &&
              (par_of(rx_word, ctrl_q[`BIT_NINE_BITS]) !=
               ctrl_q[`BIT_PARITY_TYPE]);
  end

  // Flag set events
  always_comb
  begin
    set_v = 8'h00;
    set_v[`BIT_TX_EMPTY] = tx_data_go;
    set_v[`BIT_TX_DONE] = tx_idle_cond && !done_cond_q;
    set_v[`BIT_RX_FULL] = rx_accept;
    set_v[`BIT_IDLE] = rx_idle && idle_arm_q;
    set_v[`BIT_OVERRUN] = rx_done && !rx_accept;
    set_v[`BIT_NOISE] = rx_accept && rx_noise;
    set_v[`BIT_FRAMING] = rx_accept && rx_frame;
    set_v[`BIT_PARITY] = rx_accept && rx_perr;
  end

  // Flag clear sequences, only for flags the status read saw set
  always_comb
  begin
    clr_v = 8'h00;
    clr_v[`BIT_TX_EMPTY] = wr_data && seen_q[`BIT_TX_EMPTY];
    clr_v[`BIT_TX_DONE] = (wr_data || te_rise || brk_write) &&
                          seen_q[`BIT_TX_DONE];
    clr_v[5:0] = rd_data ? seen_q[5:0] : 6'h00;
  end

  // Flag register; a set in the clearing cycle wins
  always_ff @(posedge SYS_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      status_q <= `RST_STATUS;
    else if (CLK_EN_I)
      status_q <= (status_q & ~clr_v) | set_v;
  end

  // Status read arms the clears; the matching access consumes them
  always_ff @(posedge SYS_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      seen_q <= 8'h00;
    else if (CLK_EN_I)
    begin
      if (rd_status)
        seen_q <= PRDATA_O[7:0];
      else
      begin
        if (rd_data)
          seen_q[5:0] <= 6'h00;
        if (wr_data)
          seen_q[7:6] <= 2'b00;
        else if (te_rise || brk_write)
          seen_q[`BIT_TX_DONE] <= 1'b0;
      end
    end
  end

  // Receive data register and idle arming
  always_ff @(posedge SYS_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      rx_data_q <= 9'h000;
      idle_arm_q <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      if (rx_accept)
        rx_data_q <= rx_word;
      if (rx_accept)
        idle_arm_q <= 1'b1;
      else if (rx_idle)
        idle_arm_q <= 1'b0;
    end
  end

  // Sticky events, write one to clear, and the level interrupt
  always_ff @(posedge SYS_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      event_q <= 8'h00;
      IRQ_O <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      event_q <= (event_q & ~(wr_event ? PWDATA_I[7:0] : 8'h00)) | set_v;
      IRQ_O <= |(event_q & mask_q);
    end
  end

  // Receive shifter
  serial_rx_sampler u_rx (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .ce_i(CLK_EN_I),
    .tick_i(tick_q),
    .line_i(rx_line_q),
    .nine_i(ctrl_q[`BIT_NINE_BITS]),
    .idle_sel_i(ctrl_q[`BIT_IDLE_SELECT]),
    .done_o(rx_done),
    .data_o(rx_word),
    .noise_o(rx_noise),
    .frame_o(rx_frame),
    .idle_o(rx_idle)
  );

  // Transmit shifter drives the pin from its own flop
  serial_tx_shifter u_tx (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .ce_i(CLK_EN_I),
    .tick_i(tick_q),
    .nine_i(ctrl_q[`BIT_NINE_BITS]),
    .load_i(tx_load),
    .frame_i(tx_frame),
    .busy_o(tx_busy),
    .txd_o(TXD_O)
  );
endmodule
`default_nettype wire

// [testbench/serial_status_sva.sv]
// Port checker for the serial port status block.
// Assumes one clock domain and reset asserted before traffic.
`timescale 1ns/1ps
`default_nettype none
module serial_status_sva
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic TXD_O
);
  // One domain, so one clock and one disable
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  // A status read completing at this edge
  wire st_rd = PREADY_O && !PWRITE_I && PADDR_I == 8'h00;
  // Answer comes in the second access cycle, never the first
  chk_answer_time:
    assert property ($rose(PENABLE_I) |-> !PREADY_O ##1 PREADY_O)
    else $error("ready not in second access cycle");
  chk_ready_pulse:
    assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  chk_ready_access:
    assert property (PREADY_O |-> PSEL_I && PENABLE_I
      && $past(PSEL_I && PENABLE_I))
    else $error("ready outside an access phase");
  chk_err_ready:
    assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  chk_unmapped_err:
    assert property (PREADY_O && PADDR_I[7:2] > 6'h04 |-> PSLVERR_O)
    else $error("unmapped access not refused");
  chk_write_zero:
    assert property (PREADY_O && PWRITE_I |-> PRDATA_O == 32'h0)
    else $error("read data not zero on write");
  chk_status_upper:
    assert property (st_rd |-> PRDATA_O[31:8] == 24'h0)
    else $error("status upper bits not zero");
  chk_tc_after_empty:
    assert property (st_rd && PRDATA_O[6] |-> PRDATA_O[7])
    else $error("complete without empty buffer");
  chk_err_with_full:
    assert property (st_rd && |PRDATA_O[2:0] |-> PRDATA_O[5])
    else $error("receive error without full flag");
  chk_tx_start_bit:
    assert property ($fell(TXD_O) |-> !TXD_O [*8])
    else $error("start bit too short");
endmodule
bind serial_status_top serial_status_sva i_serial_status_sva (
  .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .TXD_O(TXD_O));
`default_nettype wire

// [testbench/serial_line_model.sv]
// Remote serial station driving the receive pin of the block.
// Assumes sixteen clocks a bit; the line rests high between frames.
`timescale 1ns/1ps
`default_nettype none
module serial_line_model
(
  input wire logic clk_i,
  output logic line_o
);
  // Idle level of the line is high
  initial line_o = 1'h1;
  // Bits go LSB first; gl puts a two-clock spike in the third bit.
  // One clock would be swallowed by the pin filter, and three would
  // outvote the good samples and flip the bit.
  task automatic send(input logic [11:0] fr, input int n, input logic gl);
    for (int i = 0; i < n; i++)
      for (int j = 0; j < 16; j++)
      begin
        line_o <= fr[i] ^ (gl && i == 2 && (j == 7 || j == 8));
        @(posedge clk_i);
      end
    // Only a low stop bit needs a release; this keeps frames back to back
    if (!fr[n - 1])
      line_o <= 1'h1;
  endtask
endmodule
`default_nettype wire

// [testbench/uart_status_flags_tb.sv]
// Self-checking bench for the serial port status block.
// Assumes the line model on the receive pin and BAUD_DIV of one.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defines.svh"
module uart_status_flags_tb;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, tv;
  logic rdy, err, txd, irq;
  wire logic rxd;
  int num_errors = 0, num_checks = 0;
  logic [64:0] notes[$], nt; // {slverr, mask, expected}
  serial_status_top #(.BAUD_DIV(1)) i_serial_status_top (
    .SYS_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(1'h1), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd),
    .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err), .RXD_I(rxd),
    .TXD_O(txd), .IRQ_O(irq));
  serial_line_model i_serial_line_model (.clk_i(clk), .line_o(rxd));
  initial forever #25 clk = ~clk;
  task automatic cmp(input string n, input logic [32:0] x, g);
    num_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  // Each answer is judged against the oldest note
  always @(posedge clk)
    if (rdy === 1'h1)
    begin
      nt = notes.size() ? notes.pop_front() : 65'h0;
      cmp("apb answer", {nt[64], nt[31:0]}, {err, prd & nt[63:32]});
    end
  // Request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, m, x, input logic e);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    notes.push_back({e, m, x});
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (rdy !== 1'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 32'hFFFFFFFF, 32'h0, 1'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
    apb(1'h0, a, 32'h0, m, x, 1'h0);
  endtask
  // Releases the bus, so idle waits never look like a setup
  task automatic pause(input int n);
    psel <= 1'h0;
    pen <= 1'h0;
    repeat (n) @(posedge clk);
  endtask
  task automatic rx_case(input logic [7:0] c, input logic sb, gl, bad,
      input logic [31:0] ef);
    logic [8:0] d;
    logic [11:0] fr;
    int nd;
    d = 9'($urandom);
    nd = c[3] ? 9 : 8;
    if (!c[3])
      d[8] = 1'h0;
    if (c[1])
      d[nd - 1] = ^(d & (c[3] ? 9'h0FF : 9'h07F)) ^ c[0] ^ bad;
    fr = {3'h7, d} << 1;
    fr[nd + 1] = sb;
    wr(`OFS_CONTROL, {24'h0, c});
    pause(1);
    i_serial_line_model.send(fr, nd + 2, gl);
    pause(12);
    rd(`OFS_STATUS, 32'h2F, ef);
    rd(`OFS_DATA, 32'h1FF, {23'h0, d});
    rd(`OFS_STATUS, 32'h2F, 32'h0);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog far beyond the expected run of some 6000 cycles
  initial
  begin
    repeat (30000) @(posedge clk);
    num_errors++;
    conclude();
  end
  initial
  begin
    void'($urandom(49449));
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(`OFS_STATUS, 32'hFFFFFFFF, 32'hC0);
    rd(`OFS_CONTROL, 32'hFFFFFFFF, 32'h0);
    rd(`OFS_MASK, 32'hFFFFFFFF, 32'h0);
    wr(`OFS_STATUS, 32'hFF);
    rd(`OFS_STATUS, 32'hFFFFFFFF, 32'hC0);
    apb(1'h0, 8'h14, 32'h0, 32'hFFFFFFFF, 32'h0, 1'h1);
    apb(1'h1, 8'h18, 32'hFF, 32'hFFFFFFFF, 32'h0, 1'h1);
    $display("test registers done");
    wr(`OFS_CONTROL, 32'h10);
    // Data write, enable toggle and break each end the idle state
    for (int k = 0; k < 3; k++)
    begin
      pause(400);
      rd(`OFS_STATUS, 32'hFF, 32'hC0);
      if (k == 0)
      begin
        tv = $urandom & 32'hFF;
        wr(`OFS_DATA, tv);
        // Sample the sent character mid-bit, LSB first after the start
        pause(1);
        @(negedge txd);
        repeat (24) @(posedge clk);
        for (int b = 0; b < 8; b++)
        begin
          cmp("tx bit", {32'h0, tv[b]}, {32'h0, txd});
          repeat (16) @(posedge clk);
        end
      end
      else
      begin
        wr(`OFS_CONTROL, k == 1 ? 32'h0 : 32'h30);
        wr(`OFS_CONTROL, 32'h10);
      end
      rd(`OFS_STATUS, 32'h40, 32'h0);
    end
    pause(400);
    rd(`OFS_STATUS, 32'hFF, 32'hC0);
    wr(`OFS_DATA, $urandom & 32'hFF);
    rd(`OFS_STATUS, 32'hC0, 32'h80);
    wr(`OFS_DATA, $urandom & 32'hFF);
    rd(`OFS_STATUS, 32'hC0, 32'h0);
    pause(400);
    rd(`OFS_STATUS, 32'hC0, 32'hC0);
    $display("test transmit done");
    rx_case(8'h00, 1'h1, 1'h0, 1'h0, 32'h20);
    rx_case(8'h00, 1'h0, 1'h0, 1'h0, 32'h22);
    rx_case(8'h00, 1'h1, 1'h1, 1'h0, 32'h24);
    rx_case(8'h02, 1'h1, 1'h0, 1'h1, 32'h21);
    rx_case(8'h03, 1'h1, 1'h0, 1'h0, 32'h20);
    rx_case(8'h03, 1'h1, 1'h0, 1'h1, 32'h21);
    rx_case(8'h08, 1'h1, 1'h0, 1'h0, 32'h20);
    wr(`OFS_CONTROL, 32'h0);
    pause(1);
    i_serial_line_model.send(12'hF4A, 10, 1'h0);
    i_serial_line_model.send(12'hC78, 10, 1'h0);
    pause(12);
    rd(`OFS_STATUS, 32'h2F, 32'h28);
    rd(`OFS_DATA, 32'h1FF, 32'hA5);
    rd(`OFS_STATUS, 32'h2F, 32'h0);
    $display("test receive done");
    // All-ones character, so only the count origin differs between runs
    for (int k = 0; k < 2; k++)
    begin
      wr(`OFS_CONTROL, 32'(k << 2));
      rd(`OFS_STATUS, 32'h0, 32'h0);
      rd(`OFS_DATA, 32'h0, 32'h0);
      pause(1);
      i_serial_line_model.send(12'h3FE, 10, 1'h0);
      pause(80);
      rd(`OFS_STATUS, 32'h10, k ? 32'h0 : 32'h10);
      pause(160);
      rd(`OFS_STATUS, 32'h10, 32'h10);
    end
    wr(`OFS_EVENT, 32'hFF);
    wr(`OFS_MASK, 32'h10);
    rd(`OFS_STATUS, 32'h10, 32'h10);
    rd(`OFS_DATA, 32'h0, 32'h0);
    pause(400);
    rd(`OFS_STATUS, 32'h10, 32'h0);
    cmp("irq quiet", 33'h0, {32'h0, irq});
    pause(1);
    i_serial_line_model.send(12'hF4A, 10, 1'h0);
    pause(250);
    cmp("irq idle", 33'h1, {32'h0, irq});
    wr(`OFS_MASK, 32'h0);
    pause(2);
    cmp("irq masked", 33'h0, {32'h0, irq});
    wr(`OFS_MASK, 32'h10);
    pause(2);
    cmp("irq unmasked", 33'h1, {32'h0, irq});
    wr(`OFS_EVENT, 32'h10);
    pause(2);
    cmp("irq cleared", 33'h0, {32'h0, irq});
    rd(`OFS_EVENT, 32'h10, 32'h0);
    pause(2);
    $display("test idle done");
    conclude();
  end
endmodule
`default_nettype wire
